// ===== src/timer16_consts.svh
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// register offsets (byte addresses on the plain register port)
`define OFS_FLAGS 8'h0C
`define OFS_ENABLES 8'h0D
`define OFS_COUNT_LOW 8'h0E
`define OFS_COUNT_HIGH 8'h0F
`define OFS_TIMER_CONTROL 8'h10

// timer_control fields
`define TC_RUN_BIT 0
`define TC_CLOCK_SOURCE_SELECT 1
`define TC_SYNC_DISABLE_N 2
`define TC_OSCILLATOR_ENABLE 3
`define TC_PRESCALE_LO 4
`define TC_PRESCALE_HI 5
`define TC_WRITE_MASK 8'h3F
`define TC_RESET 8'h00

// flag / enable register fields
`define FLAG_OVERFLOW 0

// one instruction cycle is four phase clocks
`define PHASES_PER_INSTR 4

`endif

// ===== src/timer16_pkg.sv
package timer16_pkg;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} phase_e;

	typedef logic [1:0] prescale_t;

endpackage

// ===== src/ripple_prescaler.sv
`timescale 1ns/1ps
`include "timer16_consts.svh"

// divide-by-2/4/8 counter stepped by rising edges of the chosen count input
module ripple_prescaler
	import timer16_pkg::*;
#(
	parameter int STAGES = 3
) (
	// clock and clearing
	input wire logic clk,
	input wire logic clr,
	// edge input and ratio
	input wire logic edge_in,
	input wire prescale_t ratio,
	// divided level out
	output logic div_out
);

	logic [STAGES-1:0] cnt_q;
	logic [STAGES-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (clr) begin
			cnt_d = '0;
		end else if (edge_in) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		cnt_q <= cnt_d;
	end

	// 1:1 passes a one-cycle pulse; other ratios emit a symmetric square wave
	always_comb begin
		case (ratio)
			2'b00: div_out = edge_in;
			2'b01: div_out = cnt_q[0];
			2'b10: div_out = cnt_q[1];
			2'b11: div_out = cnt_q[2];
			default: div_out = 1'b0;
		endcase
	end

endmodule

// ===== src/timer16.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "timer16_consts.svh"

module timer16
	import timer16_pkg::*;
(
	// clock and resets
	input wire logic clk,
	input wire logic srst,
	input wire logic por_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// system state
	input wire logic sleep_mode,
	input wire logic compare_reset,
	// pins
	input wire logic external_count_clock_pin,
	input wire logic crystal_input_pin,
	input wire logic [1:0] port_direction_bits,
	output logic [1:0] pin_output_enable_mask,
	output logic oscillator_run,
	// results
	output logic overflow_irq,
	output logic wake_request,
	output logic [15:0] time_base,
	output logic time_base_valid
);

	// =====================================================
	// registers
	logic [7:0] timer_control_q;
	logic [7:0] timer_control_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic overflow_flag_q;
	logic overflow_flag_d;
	logic overflow_irq_enable_q;
	logic overflow_irq_enable_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	phase_e phase_q;
	phase_e phase_d;
	logic ext_prev_q;
	logic ext_prev_d;
	logic samp_q;
	logic samp_d;
	logic samp_prev_q;
	logic samp_prev_d;

	logic run_bit;
	logic clock_source_select;
	logic sync_disable_n;
	logic oscillator_enable;
	prescale_t prescale_field;
	logic wr_count_lo;
	logic wr_count_hi;
	logic count_write;
	logic ext_level;
	logic ext_rise;
	logic pre_out;
	logic pre_in;
	logic pre_clr;
	logic instr_tick;
	logic sample_now;
	logic sync_rise;
	logic unsync_rise;
	logic inc;
	logic wrap;

	assign run_bit = timer_control_q[`TC_RUN_BIT];
	assign clock_source_select = timer_control_q[`TC_CLOCK_SOURCE_SELECT];
	assign sync_disable_n = timer_control_q[`TC_SYNC_DISABLE_N];
	assign oscillator_enable = timer_control_q[`TC_OSCILLATOR_ENABLE];
	assign prescale_field =
		timer_control_q[`TC_PRESCALE_HI:`TC_PRESCALE_LO];
	assign wr_count_lo = reg_wr && (reg_addr == `OFS_COUNT_LOW);
	assign wr_count_hi = reg_wr && (reg_addr == `OFS_COUNT_HIGH);
	assign count_write = wr_count_lo || wr_count_hi;

	// =====================================================
	// pins and oscillator
	assign oscillator_run = oscillator_enable;
	// oscillator on overrides the direction bits on both pins
	assign pin_output_enable_mask = oscillator_enable ?
		2'b00 : ~port_direction_bits;
	// crystal pin when oscillator runs, external pin otherwise
	assign ext_level = oscillator_enable ?
		crystal_input_pin : external_count_clock_pin;

	// =====================================================
	// phase clocks and edge detect
	always_comb begin
		case (phase_q)
			PH_Q1: phase_d = PH_Q2;
			PH_Q2: phase_d = PH_Q3;
			PH_Q3: phase_d = PH_Q4;
			PH_Q4: phase_d = PH_Q1;
			default: phase_d = PH_Q1;
		endcase
		ext_prev_d = ext_level;
	end

	assign ext_rise = ext_level && !ext_prev_q;
	assign instr_tick = (phase_q == PH_Q4);
	// the prescaler keeps stepping in sleep; the sampler and internal-clock counting stop
	assign pre_in = clock_source_select ? ext_rise : instr_tick;
	assign pre_clr = count_write || srst;

	// =====================================================
	// prescaler ahead of the synchronizer
	ripple_prescaler #(
		.STAGES(3)
	) u_prescaler (
		.clk(clk),
		.clr(pre_clr),
		.edge_in(pre_in),
		.ratio(prescale_field),
		.div_out(pre_out)
	);

	// sample at Q2 and Q4; sampler is shut off during sleep
	assign sample_now = ((phase_q == PH_Q2) || (phase_q == PH_Q4))
		&& !sleep_mode;

	always_comb begin
		samp_d = samp_q;
		samp_prev_d = samp_prev_q;
		if (sample_now) begin
			samp_d = pre_out;
			samp_prev_d = samp_q;
		end
	end

	// at 1:1 the pulse is one cycle wide; catch it by holding till sampled
	logic pend_q;
	logic pend_d;
	always_comb begin
		pend_d = pend_q;
		if (sample_now) begin
			pend_d = 1'b0;
		end
		// a pulse on a sampling cycle is taken at once; none is held in sleep
		if (pre_out && prescale_field == 2'b00 && !sample_now &&
			!sleep_mode) begin
			pend_d = 1'b1;
		end
	end

	assign sync_rise = sample_now &&
		((prescale_field == 2'b00) ? (pend_q || pre_out) :
		(samp_q && !samp_prev_q));
	logic unsync_prev_q;
	logic unsync_prev_d;
	assign unsync_prev_d = pre_out;
	assign unsync_rise = (prescale_field == 2'b00) ? pre_out :
		(pre_out && !unsync_prev_q);

	always_comb begin
		if (!clock_source_select) begin
			// sync bit ignored in internal mode
			inc = pre_in && ((prescale_field == 2'b00) ?
				1'b1 : 1'b0) ;
			inc = (prescale_field == 2'b00) ? pre_in :
				(pre_out && !unsync_prev_q);
			inc = inc && !sleep_mode;
		end else if (!sync_disable_n) begin
			inc = sync_rise;
		end else begin
			inc = unsync_rise;
		end
		inc = inc && run_bit;
	end

	assign wrap = inc && (count_q == 16'hFFFF);

	// =====================================================
	// count, flags and control
	always_comb begin
		count_d = count_q;
		if (inc) begin
			count_d = count_q + 16'h0001;
		end
		if (compare_reset) begin
			count_d = 16'h0000;
		end
		// a write wins over the compare reset
		if (wr_count_lo) begin
			count_d = {count_q[15:8], reg_wdata};
		end
		if (wr_count_hi) begin
			count_d = {reg_wdata, count_q[7:0]};
		end

		overflow_flag_d = overflow_flag_q;
		overflow_irq_enable_d = overflow_irq_enable_q;
		if (reg_wr && reg_addr == `OFS_FLAGS) begin
			overflow_flag_d = reg_wdata[`FLAG_OVERFLOW];
		end
		if (reg_wr && reg_addr == `OFS_ENABLES) begin
			overflow_irq_enable_d = reg_wdata[`FLAG_OVERFLOW];
		end
		// set beats a simultaneous clear; compare reset never sets it
		if (wrap && !compare_reset && !count_write) begin
			overflow_flag_d = 1'b1;
		end

		timer_control_d = timer_control_q;
		if (reg_wr && reg_addr == `OFS_TIMER_CONTROL) begin
			timer_control_d = reg_wdata & `TC_WRITE_MASK;
		end
		if (por_rst) begin
			timer_control_d = `TC_RESET;
		end
	end

	// =====================================================
	// read path, registered; each count byte is read on its own, so two reads can tear
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`OFS_COUNT_LOW: rdata_d = count_q[7:0];
				`OFS_COUNT_HIGH: rdata_d = count_q[15:8];
				`OFS_TIMER_CONTROL: rdata_d = timer_control_q;
				`OFS_FLAGS: rdata_d = {7'h00, overflow_flag_q};
				`OFS_ENABLES: rdata_d = {7'h00, overflow_irq_enable_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		// count bytes are kept through every reset
		count_q <= count_d;
		ext_prev_q <= ext_prev_d;
		unsync_prev_q <= unsync_prev_d;
		if (srst) begin
			timer_control_q <= timer_control_q;
			overflow_flag_q <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
			rdata_q <= 8'h00;
			phase_q <= PH_Q1;
			samp_q <= 1'b0;
			samp_prev_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			timer_control_q <= timer_control_d;
			overflow_flag_q <= overflow_flag_d;
			overflow_irq_enable_q <= overflow_irq_enable_d;
			rdata_q <= rdata_d;
			phase_q <= phase_d;
			samp_q <= samp_d;
			samp_prev_q <= samp_prev_d;
			pend_q <= pend_d;
		end
		if (por_rst) begin
			timer_control_q <= `TC_RESET;
		end
	end

	assign reg_rdata = rdata_q;
	assign overflow_irq = overflow_flag_q && overflow_irq_enable_q;
	// only unsynchronized counting can wake a sleeping core
	assign wake_request = overflow_irq && sleep_mode &&
		clock_source_select && sync_disable_n;
	assign time_base = count_q;
	assign time_base_valid = !(clock_source_select && sync_disable_n);

endmodule

// ===== test/timer16_assertions.sv
`timescale 1ns/1ps
`include "timer16_consts.svh"
// ==========================================
// checker on the timer ports
module timer16_assertions (
	// clock and resets
	input wire logic clk,
	input wire logic srst,
	input wire logic por_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// state and pins
	input wire logic sleep_mode,
	input wire logic compare_reset,
	input wire logic [1:0] port_direction_bits,
	input wire logic [1:0] pin_output_enable_mask,
	input wire logic oscillator_run,
	// results
	input wire logic overflow_irq,
	input wire logic wake_request,
	input wire logic [15:0] time_base,
	input wire logic time_base_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// shadow of the enable bit, seen only through register writes
	logic en_q;
	logic en_d;
	always_comb begin
		en_d = en_q;
		if (reg_wr && reg_addr == `OFS_ENABLES) en_d = reg_wdata[0];
	end
	always_ff @(posedge clk) begin
		if (srst) en_q <= 1'b0;
		else en_q <= en_d;
	end
	osc_mask_a: assert property (
		oscillator_run |-> pin_output_enable_mask == 2'b00)
		else $error("pin driven while oscillator runs");
	dir_mask_a: assert property (
		!oscillator_run |-> pin_output_enable_mask == ~port_direction_bits)
		else $error("pin enable does not follow direction");
	osc_bit_a: assert property (
		reg_wr && reg_addr == `OFS_TIMER_CONTROL && !por_rst
		|=> oscillator_run == $past(reg_wdata[3]))
		else $error("oscillator run not following control");
	count_read_a: assert property (
		$past(reg_rd) && $past(reg_addr) == `OFS_COUNT_LOW
		|-> reg_rdata == $past(time_base[7:0]))
		else $error("low byte read wrong");
	step_a: assert property (
		time_base != $past(time_base) && !$past(reg_wr)
		&& !$past(compare_reset)
		|-> time_base == $past(time_base) + 16'h0001)
		else $error("count moved by other than one");
	cmp_clear_a: assert property (
		compare_reset && time_base_valid
		&& !(reg_wr && reg_addr[7:1] == 7'h07) |=> time_base == 16'h0000)
		else $error("compare reset did not clear count");
	write_wins_a: assert property (
		reg_wr && reg_addr == `OFS_COUNT_LOW && compare_reset
		|=> time_base[7:0] == $past(reg_wdata))
		else $error("compare reset beat count write");
	no_ovf_cmp_a: assert property (
		compare_reset && !overflow_irq && time_base != 16'hFFFF
		&& !(reg_wr && reg_addr == `OFS_FLAGS) |=> !overflow_irq)
		else $error("compare reset raised overflow");
	irq_mask_a: assert property (
		!en_q |-> !overflow_irq)
		else $error("irq while disabled");
	wrap_irq_a: assert property (
		en_q && !reg_wr && !compare_reset && time_base == 16'hFFFF
		##1 time_base == 16'h0000 |-> ##[0:1] overflow_irq)
		else $error("wrap without irq");
	wake_a: assert property (
		!sleep_mode |-> !wake_request)
		else $error("wake while awake");
endmodule

bind timer16 timer16_assertions chk (.clk(clk), .srst(srst),
	.por_rst(por_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sleep_mode(sleep_mode), .compare_reset(compare_reset),
	.port_direction_bits(port_direction_bits),
	.pin_output_enable_mask(pin_output_enable_mask),
	.oscillator_run(oscillator_run), .overflow_irq(overflow_irq),
	.wake_request(wake_request), .time_base(time_base),
	.time_base_valid(time_base_valid));

// ===== test/count_source.sv
`timescale 1ns/1ps
// ==========================================
// external count clock: pins rest low between bursts
module count_source (
	// timing
	input wire logic clk,
	// pins
	output logic ext_pin,
	output logic xtal_pin
);
	initial begin
		ext_pin = 1'b0;
		xtal_pin = 1'b0;
	end
	// half period well above two phase clocks, else sampling misses levels
	task automatic burst(input logic xtal, input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge clk);
			if (xtal) xtal_pin <= 1'b1;
			else ext_pin <= 1'b1;
			repeat (half) @(posedge clk);
			xtal_pin <= 1'b0;
			ext_pin <= 1'b0;
		end
	endtask
endmodule

// ===== test/sixteen_bit_timer_counter_test.sv
`timescale 1ns/1ps
`include "timer16_consts.svh"
module sixteen_bit_timer_counter_test;
	typedef struct {logic [7:0] e; logic [7:0] t;} exp_s;
	logic clk = 0, srst = 1, por_rst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic sleep_mode = 0, compare_reset = 0, rd_seen_q = 0;
	logic [1:0] port_direction_bits = 0, pin_output_enable_mask;
	logic oscillator_run, overflow_irq, wake_request, time_base_valid;
	logic ext_pin, xtal_pin;
	logic [15:0] time_base;
	logic [31:0] v;
	integer seed, err_total = 0, check_count = 0;
	exp_s exp_q[$];
	exp_s x;
	always #12.5 clk = ~clk;
	count_source src (.clk(clk), .ext_pin(ext_pin), .xtal_pin(xtal_pin));
	timer16 dut (.clk(clk), .srst(srst), .por_rst(por_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
		.compare_reset(compare_reset), .external_count_clock_pin(ext_pin),
		.crystal_input_pin(xtal_pin),
		.port_direction_bits(port_direction_bits),
		.pin_output_enable_mask(pin_output_enable_mask),
		.oscillator_run(oscillator_run), .overflow_irq(overflow_irq),
		.wake_request(wake_request), .time_base(time_base),
		.time_base_valid(time_base_valid));
	task automatic check(input string n, input logic [7:0] e, g, t);
		check_count++;
		if ((g - e <= t || e - g <= t) !== 1'b1) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// read data stand one cycle after the strobe
	always @(posedge clk) begin
		rd_seen_q <= reg_rd;
		if (rd_seen_q) begin
			x = exp_q.pop_front();
			check("reg_rdata", x.e, reg_rdata, x.t);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, d, input logic c = 1'b0);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		compare_reset <= c;
		@(posedge clk);
		reg_wr <= 1'b0;
		compare_reset <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e, t = 8'h00);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back('{e, t});
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic pin(input string n, input logic e, ref logic g);
		cyc(1);
		check(n, {7'h00, e}, {7'h00, g}, 8'h00);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		cyc(20000);
		err_total++;
		finish_test();
	end
	initial begin
		seed = 32'h86b0;
		cyc(5);
		srst <= 1'b0;
		por_rst <= 1'b0;
		rd(`OFS_TIMER_CONTROL, 8'h00);
		wr(`OFS_TIMER_CONTROL, 8'hFF);
		rd(`OFS_TIMER_CONTROL, 8'h3F);
		srst <= 1'b1;
		cyc(5);
		srst <= 1'b0;
		rd(`OFS_TIMER_CONTROL, 8'h3F);
		wr(`OFS_TIMER_CONTROL, 8'h00);
		$display("test 1 done");
		v = $random(seed);
		port_direction_bits <= v[17:16];
		wr(`OFS_COUNT_LOW, v[7:0]);
		wr(`OFS_COUNT_HIGH, v[15:8]);
		rd(`OFS_COUNT_LOW, v[7:0]);
		rd(`OFS_COUNT_HIGH, v[15:8]);
		$display("test 2 done");
		for (int p = 0; p < 4; p++) begin
			wr(`OFS_COUNT_LOW, 8'h00);
			wr(`OFS_TIMER_CONTROL, {2'b00, p[1:0], 4'h1});
			cyc(128 << p);
			wr(`OFS_TIMER_CONTROL, 8'h00);
			rd(`OFS_COUNT_LOW, 8'h20, 8'h01);
		end
		wr(`OFS_COUNT_LOW, 8'h77);
		cyc(40);
		rd(`OFS_COUNT_LOW, 8'h77);
		$display("test 3 done");
		wr(`OFS_ENABLES, 8'h01);
		wr(`OFS_COUNT_HIGH, 8'hFF);
		wr(`OFS_COUNT_LOW, 8'hFE);
		wr(`OFS_TIMER_CONTROL, 8'h01);
		cyc(20);
		wr(`OFS_TIMER_CONTROL, 8'h00);
		rd(`OFS_COUNT_HIGH, 8'h00);
		rd(`OFS_FLAGS, 8'h01);
		pin("overflow_irq", 1'b1, overflow_irq);
		wr(`OFS_ENABLES, 8'h00);
		pin("overflow_irq", 1'b0, overflow_irq);
		wr(`OFS_FLAGS, 8'h00);
		$display("test 4 done");
		wr(8'h20, 8'h55, 1'b1);
		rd(8'h20, 8'h00);
		rd(`OFS_COUNT_LOW, 8'h00);
		rd(`OFS_FLAGS, 8'h00);
		wr(`OFS_COUNT_LOW, 8'h99, 1'b1);
		rd(`OFS_COUNT_LOW, 8'h99);
		$display("test 5 done");
		wr(`OFS_COUNT_LOW, 8'h00);
		wr(`OFS_TIMER_CONTROL, 8'h03);
		src.burst(1'b0, 10, 4);
		cyc(16);
		rd(`OFS_COUNT_LOW, 8'h0A);
		wr(`OFS_TIMER_CONTROL, 8'h2B);
		cyc(8);
		wr(`OFS_COUNT_LOW, 8'h00);
		src.burst(1'b1, 12, 4);
		cyc(16);
		wr(`OFS_TIMER_CONTROL, 8'h00);
		rd(`OFS_COUNT_LOW, 8'h03);
		$display("test 6 done");
		wr(`OFS_TIMER_CONTROL, 8'h03);
		sleep_mode <= 1'b1;
		src.burst(1'b0, 8, 4);
		sleep_mode <= 1'b0;
		cyc(16);
		wr(`OFS_TIMER_CONTROL, 8'h00);
		rd(`OFS_COUNT_LOW, 8'h03);
		wr(`OFS_ENABLES, 8'h01);
		wr(`OFS_COUNT_HIGH, 8'hFF);
		wr(`OFS_COUNT_LOW, 8'hFE);
		wr(`OFS_TIMER_CONTROL, 8'h07);
		sleep_mode <= 1'b1;
		src.burst(1'b0, 3, 4);
		pin("wake_request", 1'b1, wake_request);
		pin("time_base_valid", 1'b0, time_base_valid);
		sleep_mode <= 1'b0;
		wr(`OFS_TIMER_CONTROL, 8'h00);
		rd(`OFS_COUNT_HIGH, 8'h00);
		rd(`OFS_COUNT_LOW, 8'h01);
		rd(`OFS_COUNT_HIGH, 8'h00);
		$display("test 7 done");
		cyc(4);
		finish_test();
	end
endmodule
